// *** dv/backlight_level_current_regs_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module backlight_level_current_regs_bench;
    import blcr_pkg::*;
    logic           mclk, rst, dim_timeout, dim_en, rd_hit;
    logic [7:0]     rd_addr, rd_data;
    logic [6:0]     dmax, ddim, regs [4];
    blcr_level_type level;
    blcr_wr_type    wr;
    blcr_drive_type drive;
    int             num_errors = 0;
    int             compares = 0;
    int             i;
    blcr_host host (.mclk(mclk), .wr(wr));
    blcr_regs dut (.mclk(mclk), .rst(rst), .wr(wr), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_hit(rd_hit), .level(level),
        .dim_timeout(dim_timeout), .dim_en(dim_en),
        .daylight_max_code(dmax), .dark_dim_code(ddim), .drive(drive));
    // Generic byte compare, used for readback and drive
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Expected drive from the level and the dim sources
    function automatic logic [7:0] exp_drv(int lv, logic dm);
        case (lv)
            0: return {dm, dm ? regs[0] : dmax};
            1: return {dm, dm ? regs[2] : regs[1]};
            2: return {dm, dm ? ddim : regs[3]};
            default: return {dm, 7'h00};
        endcase
    endfunction
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Free-running clock
    initial begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        rst = 1; rd_addr = 8'h00; level = BLCR_LVL_DAYLIGHT;
        dim_timeout = 0; dim_en = 0; dmax = 7'h00; ddim = 7'h00;
        void'($urandom(39694));
        repeat (12) @(posedge mclk);
        #1 rst = 0;
        // Reserved bit dropped, all four places mapped
        for (i = 0; i < 4; i++) begin
            host.put(8'h0a + i, 8'hff);
            regs[i] = 7'h7f;
            rd_addr = 8'h0a + i;
            #1 chk(rd_data, 8'h7f);
            chk({7'h00, rd_hit}, 8'h01);
        end
        // Unmapped places refuse writes and read zero
        host.put(8'h0e, 8'hff);
        rd_addr = 8'h0e;
        #1 chk({rd_hit, rd_data[6:0]}, 8'h00);
        $display("test regs done");
        // Every level against every dim source, random codes
        for (i = 0; i < 64; i++) begin
            regs[i % 4] = 7'($urandom());
            host.put(8'h0a + 8'(i % 4), {1'($urandom()), regs[i % 4]});
            level = blcr_level_type'(i % 4);
            {dim_timeout, dim_en} = 2'(i / 4);
            dmax = 7'($urandom());
            ddim = 7'($urandom());
            rd_addr = 8'h0a + 8'(i % 4);
            repeat (2) @(posedge mclk);
            #1 chk(drive, exp_drv(i % 4, dim_timeout | dim_en));
            chk(rd_data, {1'b0, regs[i % 4]});
        end
        $display("test drive done");
        end_of_test();
    end
endmodule
`default_nettype wire

// *** dv/blcr_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module blcr_host
    import blcr_pkg::*;
(
    // Clock
    input  wire logic  mclk,
    // Writes into the bank
    output blcr_wr_type wr
);
    initial wr = '0;
    // One-cycle strobe, raised just after an edge
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 wr = '{1'b1, a, d};
        @(posedge mclk);
        #1 wr.wr_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** rtl/blcr_map.svh ***
// What this block does
// - Daylight dim code held, driven after timeout
// - Office max code in bits 6:0
// - Office dim code in bits 6:0
// - Dim code on timeout or dim enable
// - Dark max code in bits 6:0
`ifndef BLCR_MAP_SVH
`define BLCR_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BLCR_DAYLIGHT_DIM_OFS 8'h0a
`define BLCR_OFFICE_MAX_OFS   8'h0b
`define BLCR_OFFICE_DIM_OFS   8'h0c
`define BLCR_DARK_MAX_OFS     8'h0d

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define BLCR_CODE_MSB         6
`define BLCR_CODE_LSB         0
`define BLCR_CODE_RESET       7'h00

`endif

// *** rtl/blcr_pkg.sv ***
package blcr_pkg;

    // Ambient light level seen by the backlight
    typedef enum logic [1:0] {
        BLCR_LVL_DAYLIGHT,
        BLCR_LVL_OFFICE,
        BLCR_LVL_DARK
    } blcr_level_type;

    // Register write request from the serial interface
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } blcr_wr_type;

    // Selected backlight drive
    typedef struct packed {
        logic       dimmed;
        logic [6:0] code;
    } blcr_drive_type;

endpackage

// *** rtl/blcr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "blcr_map.svh"

module blcr_regs
    import blcr_pkg::*;
(
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           rst,
    // Register access from the serial interface
    input  wire blcr_wr_type    wr,
    input  wire logic [7:0]     rd_addr,
    output logic [7:0]          rd_data,
    output logic                rd_hit,
    // Backlight control
    input  wire blcr_level_type level,
    input  wire logic           dim_timeout,
    input  wire logic           dim_en,
    input  wire logic [6:0]     daylight_max_code,
    input  wire logic [6:0]     dark_dim_code,
    output blcr_drive_type      drive
);

    // ----------------------------------------------------------------
    // Level current registers
    // ----------------------------------------------------------------
    logic [6:0] daylight_dim_code_q;
    logic [6:0] office_max_code_q;
    logic [6:0] office_dim_code_q;
    logic [6:0] dark_max_code_q;
    logic [6:0] wcode;

    // Bit 7 of write data is dropped on purpose
    assign wcode = wr.wdata[`BLCR_CODE_MSB:`BLCR_CODE_LSB];

    // Daylight dim code
    always_ff @(posedge mclk) begin
        if (rst) begin
            daylight_dim_code_q <= `BLCR_CODE_RESET;
        end else if (wr.wr_en && wr.addr == `BLCR_DAYLIGHT_DIM_OFS) begin
            daylight_dim_code_q <= wcode;
        end
    end

    // Office max code
    always_ff @(posedge mclk) begin
        if (rst) begin
            office_max_code_q <= `BLCR_CODE_RESET;
        end else if (wr.wr_en && wr.addr == `BLCR_OFFICE_MAX_OFS) begin
            office_max_code_q <= wcode;
        end
    end

    // Office dim code
    always_ff @(posedge mclk) begin
        if (rst) begin
            office_dim_code_q <= `BLCR_CODE_RESET;
        end else if (wr.wr_en && wr.addr == `BLCR_OFFICE_DIM_OFS) begin
            office_dim_code_q <= wcode;
        end
    end

    // Dark max code
    always_ff @(posedge mclk) begin
        if (rst) begin
            dark_max_code_q <= `BLCR_CODE_RESET;
        end else if (wr.wr_en && wr.addr == `BLCR_DARK_MAX_OFS) begin
            dark_max_code_q <= wcode;
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Top bit always zero; unmapped addresses read zero with no hit
    always_comb begin
        rd_data = 8'h00;
        rd_hit  = 1'b1;
        unique case (rd_addr)
            `BLCR_DAYLIGHT_DIM_OFS: rd_data = {1'b0, daylight_dim_code_q};
            `BLCR_OFFICE_MAX_OFS:   rd_data = {1'b0, office_max_code_q};
            `BLCR_OFFICE_DIM_OFS:   rd_data = {1'b0, office_dim_code_q};
            `BLCR_DARK_MAX_OFS:     rd_data = {1'b0, dark_max_code_q};
            default:                rd_hit  = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Drive selection
    // ----------------------------------------------------------------
    blcr_drive_type drive_d;
    logic           dim_sel;

    // Either cause dims; the timer itself lives outside this block
    assign dim_sel = dim_timeout | dim_en;

    always_comb begin
        drive_d.dimmed = dim_sel;
        drive_d.code   = 7'h00;
        unique case (level)
            BLCR_LVL_DAYLIGHT: drive_d.code = dim_sel ? daylight_dim_code_q
                                                      : daylight_max_code;
            BLCR_LVL_OFFICE:   drive_d.code = dim_sel ? office_dim_code_q
                                                      : office_max_code_q;
            BLCR_LVL_DARK:     drive_d.code = dim_sel ? dark_dim_code
                                                      : dark_max_code_q;
            default:           drive_d.code = 7'h00;
        endcase
    end

    // Registered so the DAC sees no glitches
    always_ff @(posedge mclk) begin
        if (rst) begin
            drive <= '0;
        end else begin
            drive <= drive_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    daylight_dim_drive_a: assert property (
        level == BLCR_LVL_DAYLIGHT && dim_timeout
        |=> drive.code == $past(daylight_dim_code_q))
        else $error("daylight dim code not driven");
    office_max_store_a: assert property (
        wr.wr_en && wr.addr == `BLCR_OFFICE_MAX_OFS
        |=> office_max_code_q == $past(wr.wdata[6:0]))
        else $error("office max code not stored");
    office_dim_store_a: assert property (
        wr.wr_en && wr.addr == `BLCR_OFFICE_DIM_OFS
        |=> office_dim_code_q == $past(wr.wdata[6:0]))
        else $error("office dim code not stored");
    dim_select_a: assert property (
        (dim_timeout || dim_en) && level == BLCR_LVL_OFFICE
        |=> drive.dimmed && drive.code == $past(office_dim_code_q))
        else $error("dim code not selected");
    undimmed_select_a: assert property (
        !dim_timeout && !dim_en && level == BLCR_LVL_DARK
        |=> !drive.dimmed && drive.code == $past(dark_max_code_q))
        else $error("max code not selected");
    dark_max_store_a: assert property (
        wr.wr_en && wr.addr == `BLCR_DARK_MAX_OFS
        |=> dark_max_code_q == $past(wr.wdata[6:0]))
        else $error("dark max code not stored");
    reserved_zero_a: assert property (
        rd_hit |-> rd_data[7] == 1'b0)
        else $error("reserved bit read as one");
    daylight_store_a: assert property (
        wr.wr_en && wr.addr == `BLCR_DAYLIGHT_DIM_OFS
        |=> daylight_dim_code_q == $past(wr.wdata[6:0]))
        else $error("daylight dim code not stored");

    timeout_dim_c: cover property (
        level == BLCR_LVL_DAYLIGHT && dim_timeout ##1 drive.dimmed);
    user_dim_c: cover property (
        level == BLCR_LVL_OFFICE && dim_en && !dim_timeout);
    write_read_c: cover property (
        wr.wr_en && wr.wdata[7] ##1 rd_hit);

endmodule

`default_nettype wire
